// file: core/rxcfg_pkg.sv
package rxcfg_pkg;

   // register offsets: the first lives in space B, the rest in space A
   localparam logic [5:0] RXCFG_ADDR_PASSIVE  = 6'h0b;
   localparam logic [5:0] RXCFG_ADDR_DEMOD    = 6'h0c;
   localparam logic [5:0] RXCFG_ADDR_GAIN1    = 6'h0d;
   localparam logic [5:0] RXCFG_ADDR_GAIN2    = 6'h0e;

   // values after reset
   localparam logic [7:0] RXCFG_RST_PASSIVE   = 8'h0c;
   localparam logic [7:0] RXCFG_RST_DEMOD     = 8'h2c;
   localparam logic [7:0] RXCFG_RST_GAIN1     = 8'hd8;
   localparam logic [7:0] RXCFG_RST_GAIN2     = 8'h00;

   // demodulator / gain control register fields
   localparam int RXCFG_BIT_DEMOD_IQ   = 7;
   localparam int RXCFG_BIT_AMD_MIXER  = 6;
   localparam int RXCFG_BIT_SQ_AUTO    = 5;
   localparam int RXCFG_BIT_SQ_RATIO   = 4;
   localparam int RXCFG_BIT_AGC_EN     = 3;
   localparam int RXCFG_BIT_AGC_WHOLE  = 2;
   localparam int RXCFG_BIT_AGC_ALG    = 1;
   localparam int RXCFG_BIT_AGC_RATIO  = 0;

   // first-stage gain register fields
   localparam int RXCFG_POS_AM_GAIN1   = 5;
   localparam int RXCFG_POS_PM_GAIN1   = 2;
   localparam int RXCFG_BIT_LF_INPUT   = 1;
   localparam int RXCFG_BIT_LF_SPLIT   = 0;

   // second-stage gain register fields
   localparam int RXCFG_POS_AM_GAIN2   = 4;
   localparam int RXCFG_POS_PM_GAIN2   = 0;

   // passive target register fields
   localparam int RXCFG_BIT_ONOFF_FD   = 7;
   localparam int RXCFG_POS_ONOFF_TC   = 5;
   localparam int RXCFG_POS_OOK_THD    = 3;
   localparam int RXCFG_POS_AMP_TC     = 1;
   localparam int RXCFG_BIT_ASK_THD    = 0;

   // first-stage gain in half-dB units
   localparam logic signed [6:0] RXCFG_GAIN1_STEP  = 7'sh05;
   localparam logic signed [6:0] RXCFG_GAIN1_BOOST = 7'sh0b;
   localparam logic [2:0]        RXCFG_GAIN1_BOOST_CODE = 3'h7;

   // later-stage gain codes
   localparam logic [3:0] RXCFG_GAIN2_MAX     = 4'ha;
   localparam logic [3:0] RXCFG_GAIN2_WIN_MAX = 4'h4;

   // detector thresholds in percent
   localparam logic [6:0] RXCFG_OOK_THR_SLOW  = 7'h37;
   localparam logic [6:0] RXCFG_OOK_THR_FAST  = 7'h50;
   localparam logic [6:0] RXCFG_OOK_STEP_SLOW = 7'h0a;
   localparam logic [6:0] RXCFG_OOK_STEP_FAST = 7'h05;
   localparam logic [6:0] RXCFG_ASK_THR_HI    = 7'h61;
   localparam logic [6:0] RXCFG_ASK_THR_LO    = 7'h5f;

   // squelch start delay after end of transmit
   localparam int         RXCFG_CLK_PERIOD_NS  = 25;
   localparam int         RXCFG_SQ_DELAY_NS    = 18880;
   localparam int         RXCFG_SQ_DELAY_CYC   =
      (RXCFG_SQ_DELAY_NS + RXCFG_CLK_PERIOD_NS - 1) / RXCFG_CLK_PERIOD_NS;
   localparam logic [9:0] RXCFG_SQ_DELAY_LAST  = 10'(RXCFG_SQ_DELAY_CYC - 1);

   // gain control window on the first subcarrier pulses
   localparam logic [3:0] RXCFG_AGC_FIRST_PULSES = 4'h8;

   typedef enum logic [1:0] {
      SQ_IDLE   = 2'b00,
      SQ_WAIT   = 2'b01,
      SQ_ACTIVE = 2'b10
   } rxcfg_sq_state_type;

endpackage : rxcfg_pkg

// file: core/rxcfg_later_gain.sv
`timescale 1ns/1ps
module rxcfg_later_gain
   import rxcfg_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // staged code and reload strobe
   input  wire logic [3:0] code,
   input  wire logic       load,
   // active settings
   output logic [3:0]      active_code_q,
   output logic [3:0]      window_steps_q,
   output logic [3:0]      stage_steps_q
);

   logic [3:0] clamped;

   // unused codes above the top setting behave as the top setting
   assign clamped = (code > RXCFG_GAIN2_MAX) ? RXCFG_GAIN2_MAX : code;

   // the register value only reaches the gain logic on the reload command
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         active_code_q  <= 4'h0;
         window_steps_q <= 4'h0;
         stage_steps_q  <= 4'h0;
      end else if (load) begin
         active_code_q  <= clamped;
         window_steps_q <= (clamped > RXCFG_GAIN2_WIN_MAX) ? RXCFG_GAIN2_WIN_MAX : clamped;
         stage_steps_q  <= (clamped > RXCFG_GAIN2_WIN_MAX) ?
                           4'(clamped - RXCFG_GAIN2_WIN_MAX) : 4'h0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   a_gain_hold_noload: assert property (!load |=> $stable(active_code_q))
      else $error("later gain changed without reload");

   a_gain_split_sum: assert property (load |=> (4'(window_steps_q + stage_steps_q)
                                      == active_code_q) && active_code_q <= RXCFG_GAIN2_MAX)
      else $error("later gain split wrong");

endmodule : rxcfg_later_gain

// file: core/rxcfg_regs.sv
`timescale 1ns/1ps
// Function
// - bit 7 picks I/Q; needs mixer
// - auto squelch 18.88 us after transmit end
// - squelch ratio bit picks 1 or 6/3
// - gain control enable and whole-period select
// - gain control algorithm: preset or reset
// - gain control trigger ratio 3 or 6
// - AM first stage: full, -2.5dB steps, boost
// - PM first stage uses same coding
// - selects HF or LF receive input
// - LF differential or split to AM/PM
// - later stage codes 0h..Ah, 3dB steps
// - second-stage gains load on gain reset
// - on-off time constant and fast decay
// - on-off threshold depends on time constant
// - amplitude time constant and 97/95% threshold
module rxcfg_regs
   import rxcfg_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   // register access from the host port decoder
   input  wire logic        reg_space_b,
   input  wire logic [5:0]  reg_addr,
   input  wire logic        reg_wr_en,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd_en,
   output logic [7:0]       reg_rdata_q,
   // direct command
   input  wire logic        gain_reset_cmd,
   // receive path events
   input  wire logic        tx_end,
   input  wire logic        mask_timer_at_squelch,
   input  wire logic        rx_on,
   input  wire logic        subcarrier_pulse,
   // demodulator and squelch
   output logic             demod_iq_q,
   output logic             demod_cfg_error_q,
   output logic             amd_mixer_q,
   output logic             squelch_active_q,
   output logic             squelch_ratio_high_q,
   // gain control
   output logic             agc_active_q,
   output logic             agc_reset_alg_q,
   output logic             gain_control_ratio_q,
   // first stage gain, signed half-dB
   output logic signed [6:0] am_first_stage_gain_q,
   output logic signed [6:0] pm_first_stage_gain_q,
   output logic             low_freq_input_enable_q,
   output logic             low_freq_split_mode_q,
   // later stage gain, active after reload
   output logic [3:0]       am_later_stage_gain_q,
   output logic [3:0]       am_window_steps_q,
   output logic [3:0]       am_stage_steps_q,
   output logic [3:0]       pm_later_stage_gain_q,
   output logic [3:0]       pm_window_steps_q,
   output logic [3:0]       pm_stage_steps_q,
   // passive target detectors
   output logic             onoff_fast_decay_q,
   output logic [1:0]       onoff_time_constant_q,
   output logic [6:0]       onoff_threshold_pct_q,
   output logic [1:0]       amplitude_time_constant_q,
   output logic [6:0]       amplitude_threshold_pct_q
);

   logic [7:0]          passive_target_rx_config_q;
   logic [7:0]          rx_demod_agc_config_q;
   logic [7:0]          rx_first_stage_gain_q;
   logic [7:0]          rx_second_stage_gain_q;
   logic                sel_passive;
   logic                sel_demod;
   logic                sel_gain1;
   logic                sel_gain2;
   rxcfg_sq_state_type  sq_state_q;
   logic [9:0]          sq_cnt_q;
   logic [3:0]          pulse_cnt_q;
   logic [1:0]          onoff_tc;
   logic [1:0]          ook_thd;

   assign sel_passive = reg_space_b && (reg_addr == RXCFG_ADDR_PASSIVE);
   assign sel_demod   = !reg_space_b && (reg_addr == RXCFG_ADDR_DEMOD);
   assign sel_gain1   = !reg_space_b && (reg_addr == RXCFG_ADDR_GAIN1);
   assign sel_gain2   = !reg_space_b && (reg_addr == RXCFG_ADDR_GAIN2);

   function automatic logic signed [6:0] first_gain(input logic [2:0] code);
      logic signed [6:0] g;
      g = 7'sh00;
      if (code == RXCFG_GAIN1_BOOST_CODE) begin
         g = RXCFG_GAIN1_BOOST;
      end else begin
         g = 7'(-(RXCFG_GAIN1_STEP * $signed({4'h0, code})));
      end
      return g;
   endfunction : first_gain

   // register storage
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         passive_target_rx_config_q <= RXCFG_RST_PASSIVE;
         rx_demod_agc_config_q      <= RXCFG_RST_DEMOD;
         rx_first_stage_gain_q      <= RXCFG_RST_GAIN1;
         rx_second_stage_gain_q     <= RXCFG_RST_GAIN2;
      end else if (reg_wr_en) begin
         if (sel_passive) passive_target_rx_config_q <= reg_wdata;
         if (sel_demod)   rx_demod_agc_config_q      <= reg_wdata;
         if (sel_gain1)   rx_first_stage_gain_q      <= reg_wdata;
         if (sel_gain2)   rx_second_stage_gain_q     <= reg_wdata;
      end
   end

   // read data stands until the next read; unmapped reads give zero
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rdata_q <= sel_passive ? passive_target_rx_config_q :
                        sel_demod   ? rx_demod_agc_config_q :
                        sel_gain1   ? rx_first_stage_gain_q :
                        sel_gain2   ? rx_second_stage_gain_q : 8'h00;
      end
   end

   // demodulator and static gain control settings
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         demod_iq_q           <= 1'b0;
         demod_cfg_error_q    <= 1'b0;
         amd_mixer_q          <= 1'b0;
         squelch_ratio_high_q <= 1'b0;
         agc_reset_alg_q      <= 1'b0;
         gain_control_ratio_q <= 1'b0;
      end else begin
         // I/Q without the mixer is meaningless, so it falls back to AM/PM
         demod_iq_q        <= rx_demod_agc_config_q[RXCFG_BIT_DEMOD_IQ] &&
                              rx_demod_agc_config_q[RXCFG_BIT_AMD_MIXER];
         demod_cfg_error_q <= rx_demod_agc_config_q[RXCFG_BIT_DEMOD_IQ] &&
                              !rx_demod_agc_config_q[RXCFG_BIT_AMD_MIXER];
         amd_mixer_q          <= rx_demod_agc_config_q[RXCFG_BIT_AMD_MIXER];
         squelch_ratio_high_q <= rx_demod_agc_config_q[RXCFG_BIT_SQ_RATIO];
         agc_reset_alg_q      <= rx_demod_agc_config_q[RXCFG_BIT_AGC_ALG];
         gain_control_ratio_q <= rx_demod_agc_config_q[RXCFG_BIT_AGC_RATIO];
      end
   end

   // automatic squelch sequencing
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sq_state_q       <= SQ_IDLE;
         sq_cnt_q         <= 10'h000;
         squelch_active_q <= 1'b0;
      end else if (!rx_demod_agc_config_q[RXCFG_BIT_SQ_AUTO]) begin
         sq_state_q       <= SQ_IDLE;
         sq_cnt_q         <= 10'h000;
         squelch_active_q <= 1'b0;
      end else begin
         unique case (sq_state_q)
            SQ_IDLE: begin
               if (tx_end) begin
                  sq_state_q <= SQ_WAIT;
                  sq_cnt_q   <= 10'h000;
               end
            end
            SQ_WAIT: begin
               if (sq_cnt_q == RXCFG_SQ_DELAY_LAST) begin
                  sq_state_q       <= SQ_ACTIVE;
                  squelch_active_q <= 1'b1;
               end else begin
                  sq_cnt_q <= 10'(sq_cnt_q + 10'h001);
               end
            end
            SQ_ACTIVE: begin
               if (mask_timer_at_squelch) begin
                  sq_state_q       <= SQ_IDLE;
                  squelch_active_q <= 1'b0;
               end
            end
            default: begin
               sq_state_q       <= SQ_IDLE;
               squelch_active_q <= 1'b0;
            end
         endcase
      end
   end

   // subcarrier pulse count bounds the short gain control window
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !rx_on) begin
         pulse_cnt_q <= 4'h0;
      end else if (subcarrier_pulse && pulse_cnt_q != RXCFG_AGC_FIRST_PULSES) begin
         pulse_cnt_q <= 4'(pulse_cnt_q + 4'h1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         agc_active_q <= 1'b0;
      end else begin
         agc_active_q <= rx_demod_agc_config_q[RXCFG_BIT_AGC_EN] && rx_on &&
                         (rx_demod_agc_config_q[RXCFG_BIT_AGC_WHOLE] ||
                          pulse_cnt_q != RXCFG_AGC_FIRST_PULSES);
      end
   end

   // first stage gain and input routing
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         am_first_stage_gain_q   <= 7'sh00;
         pm_first_stage_gain_q   <= 7'sh00;
         low_freq_input_enable_q <= 1'b0;
         low_freq_split_mode_q   <= 1'b0;
      end else begin
         am_first_stage_gain_q   <= first_gain(rx_first_stage_gain_q[RXCFG_POS_AM_GAIN1 +: 3]);
         pm_first_stage_gain_q   <= first_gain(rx_first_stage_gain_q[RXCFG_POS_PM_GAIN1 +: 3]);
         low_freq_input_enable_q <= rx_first_stage_gain_q[RXCFG_BIT_LF_INPUT];
         low_freq_split_mode_q   <= rx_first_stage_gain_q[RXCFG_BIT_LF_SPLIT];
      end
   end

   // later stage gain, one instance per channel
   rxcfg_later_gain u_am_later (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .code           (rx_second_stage_gain_q[RXCFG_POS_AM_GAIN2 +: 4]),
      .load           (gain_reset_cmd),
      .active_code_q  (am_later_stage_gain_q),
      .window_steps_q (am_window_steps_q),
      .stage_steps_q  (am_stage_steps_q)
   );

   rxcfg_later_gain u_pm_later (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .code           (rx_second_stage_gain_q[RXCFG_POS_PM_GAIN2 +: 4]),
      .load           (gain_reset_cmd),
      .active_code_q  (pm_later_stage_gain_q),
      .window_steps_q (pm_window_steps_q),
      .stage_steps_q  (pm_stage_steps_q)
   );

   // passive target detectors
   assign onoff_tc = passive_target_rx_config_q[RXCFG_POS_ONOFF_TC +: 2];
   assign ook_thd  = passive_target_rx_config_q[RXCFG_POS_OOK_THD +: 2];

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         onoff_fast_decay_q        <= 1'b0;
         onoff_time_constant_q     <= 2'h0;
         onoff_threshold_pct_q     <= 7'h00;
         amplitude_time_constant_q <= 2'h0;
         amplitude_threshold_pct_q <= 7'h00;
      end else begin
         onoff_fast_decay_q    <= passive_target_rx_config_q[RXCFG_BIT_ONOFF_FD];
         onoff_time_constant_q <= onoff_tc;
         onoff_threshold_pct_q <= (onoff_tc == 2'h0) ?
            7'(RXCFG_OOK_THR_SLOW - RXCFG_OOK_STEP_SLOW * {5'h00, ook_thd}) :
            7'(RXCFG_OOK_THR_FAST - RXCFG_OOK_STEP_FAST * {5'h00, ook_thd});
         amplitude_time_constant_q <= passive_target_rx_config_q[RXCFG_POS_AMP_TC +: 2];
         amplitude_threshold_pct_q <= passive_target_rx_config_q[RXCFG_BIT_ASK_THD] ?
                                      RXCFG_ASK_THR_LO : RXCFG_ASK_THR_HI;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_sq_armed;
      sq_state_q == SQ_IDLE && tx_end && rx_demod_agc_config_q[RXCFG_BIT_SQ_AUTO];
   endsequence

   sequence s_sq_waiting;
      sq_state_q == SQ_WAIT && !squelch_active_q;
   endsequence

   a_reset_defaults: assert property ($past(sys_rst) |->
      rx_demod_agc_config_q == RXCFG_RST_DEMOD && rx_first_stage_gain_q == RXCFG_RST_GAIN1 &&
      passive_target_rx_config_q == RXCFG_RST_PASSIVE)
      else $error("registers not at defaults after reset");

   a_reg_readback: assert property (reg_wr_en && sel_gain1 ##1 reg_rd_en && sel_gain1 &&
      !reg_wr_en |=> reg_rdata_q == $past(reg_wdata, 2))
      else $error("read back differs from write");

   a_iq_needs_mixer: assert property (demod_iq_q |-> $past(rx_demod_agc_config_q[RXCFG_BIT_AMD_MIXER]))
      else $error("I/Q mode without mixer");

   a_squelch_wait: assert property (s_sq_armed |=> s_sq_waiting [*8])
      else $error("squelch started too early");

   a_squelch_delay: assert property ($rose(squelch_active_q) |->
      $past(sq_cnt_q) == RXCFG_SQ_DELAY_LAST)
      else $error("squelch start delay wrong");

   a_squelch_release: assert property (squelch_active_q && mask_timer_at_squelch &&
      rx_demod_agc_config_q[RXCFG_BIT_SQ_AUTO] |=> !squelch_active_q)
      else $error("squelch not released by mask timer");

   a_agc_short_window: assert property (rx_on && !rx_demod_agc_config_q[RXCFG_BIT_AGC_WHOLE] &&
      pulse_cnt_q == RXCFG_AGC_FIRST_PULSES |=> !agc_active_q)
      else $error("gain control ran past first pulses");

   a_first_gain_boost: assert property (rx_first_stage_gain_q[RXCFG_POS_AM_GAIN1 +: 3] ==
      RXCFG_GAIN1_BOOST_CODE |=> am_first_stage_gain_q == RXCFG_GAIN1_BOOST)
      else $error("first stage boost wrong");

   a_ook_thresh_fast: assert property (onoff_tc != 2'h0 && ook_thd == 2'h3 |=>
      onoff_threshold_pct_q == 7'h41)
      else $error("on-off threshold wrong");

   a_ask_thresh: assert property (passive_target_rx_config_q[RXCFG_BIT_ASK_THD] |=>
      amplitude_threshold_pct_q == RXCFG_ASK_THR_LO)
      else $error("amplitude threshold wrong");

endmodule : rxcfg_regs

// file: bench/rxcfg_testbench.sv
`timescale 1ns/1ps
module testbench
   import rxcfg_pkg::*;
;
   logic              sys_clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              reg_space_b = 1'b0;
   logic [5:0]        reg_addr = 6'h00;
   logic              reg_wr_en = 1'b0;
   logic [7:0]        reg_wdata = 8'h00;
   logic              reg_rd_en = 1'b0;
   logic              gain_reset_cmd = 1'b0;
   logic              tx_end = 1'b0;
   logic              mask_timer_at_squelch = 1'b0;
   logic              rx_on = 1'b0;
   logic              subcarrier_pulse = 1'b0;
   logic [7:0]        reg_rdata_q;
   logic              demod_iq_q, demod_cfg_error_q, amd_mixer_q;
   logic              squelch_active_q, squelch_ratio_high_q;
   logic              agc_active_q, agc_reset_alg_q, gain_control_ratio_q;
   logic signed [6:0] am_first_stage_gain_q, pm_first_stage_gain_q;
   logic              low_freq_input_enable_q, low_freq_split_mode_q;
   logic [3:0]        am_later_stage_gain_q, am_window_steps_q, am_stage_steps_q;
   logic [3:0]        pm_later_stage_gain_q, pm_window_steps_q, pm_stage_steps_q;
   logic              onoff_fast_decay_q;
   logic [1:0]        onoff_time_constant_q, amplitude_time_constant_q;
   logic [6:0]        onoff_threshold_pct_q, amplitude_threshold_pct_q;
   int                failures = 0;
   int                cmp_count = 0;

   rxcfg_regs dut_u (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_space_b(reg_space_b),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
      .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q), .gain_reset_cmd(gain_reset_cmd),
      .tx_end(tx_end), .mask_timer_at_squelch(mask_timer_at_squelch), .rx_on(rx_on),
      .subcarrier_pulse(subcarrier_pulse), .demod_iq_q(demod_iq_q),
      .demod_cfg_error_q(demod_cfg_error_q), .amd_mixer_q(amd_mixer_q),
      .squelch_active_q(squelch_active_q), .squelch_ratio_high_q(squelch_ratio_high_q),
      .agc_active_q(agc_active_q), .agc_reset_alg_q(agc_reset_alg_q),
      .gain_control_ratio_q(gain_control_ratio_q),
      .am_first_stage_gain_q(am_first_stage_gain_q),
      .pm_first_stage_gain_q(pm_first_stage_gain_q),
      .low_freq_input_enable_q(low_freq_input_enable_q),
      .low_freq_split_mode_q(low_freq_split_mode_q),
      .am_later_stage_gain_q(am_later_stage_gain_q), .am_window_steps_q(am_window_steps_q),
      .am_stage_steps_q(am_stage_steps_q), .pm_later_stage_gain_q(pm_later_stage_gain_q),
      .pm_window_steps_q(pm_window_steps_q), .pm_stage_steps_q(pm_stage_steps_q),
      .onoff_fast_decay_q(onoff_fast_decay_q), .onoff_time_constant_q(onoff_time_constant_q),
      .onoff_threshold_pct_q(onoff_threshold_pct_q),
      .amplitude_time_constant_q(amplitude_time_constant_q),
      .amplitude_threshold_pct_q(amplitude_threshold_pct_q)
   );

   always #12.5 sys_clk = ~sys_clk;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   // all drivers start and end at a falling edge
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc

   task automatic reg_wr(input logic b, input logic [5:0] a, input logic [7:0] d);
      reg_space_b = b;
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      cyc(1);
      reg_wr_en = 1'b0;
      cyc(1);
   endtask : reg_wr

   task automatic reg_rd(input logic b, input logic [5:0] a, output logic [7:0] d);
      reg_space_b = b;
      reg_addr = a;
      reg_rd_en = 1'b1;
      cyc(1);
      reg_rd_en = 1'b0;
      d = reg_rdata_q;
      cyc(1);
   endtask : reg_rd

   task automatic scp_pulse(input int n);
      repeat (n) begin
         subcarrier_pulse = 1'b1;
         cyc(1);
         subcarrier_pulse = 1'b0;
         cyc(1);
      end
   endtask : scp_pulse

   function automatic logic [6:0] gain1_exp(input int c);
      return (c == 0) ? 7'h00 : (c == 7) ? 7'h0b : 7'(-5 * c);
   endfunction : gain1_exp

   task automatic test_reset_and_map();
      logic [7:0] d;
      reg_rd(1'b1, 6'h0b, d);
      check(d, 8'h0c, "passive default");
      reg_rd(1'b0, 6'h0c, d);
      check(d, 8'h2c, "demod default");
      reg_rd(1'b0, 6'h0d, d);
      check(d, 8'hd8, "gain1 default");
      reg_rd(1'b0, 6'h0e, d);
      check(d, 8'h00, "gain2 default");
      check({1'b0, am_first_stage_gain_q}, 8'h62, "am gain default");
      check({1'b0, onoff_threshold_pct_q}, 8'h2d, "ook thr default");
      reg_wr(1'b1, 6'h0c, 8'hff);
      reg_wr(1'b0, 6'h3f, 8'hff);
      reg_rd(1'b0, 6'h0c, d);
      check(d, 8'h2c, "wrong space write");
      reg_rd(1'b0, 6'h0b, d);
      check(d, 8'h00, "space a 0x0b read");
      reg_rd(1'b0, 6'h3f, d);
      check(d, 8'h00, "unmapped read");
      // write then read on the very next edge
      reg_space_b = 1'b0;
      reg_addr = 6'h0d;
      reg_wdata = 8'h5a;
      reg_wr_en = 1'b1;
      cyc(1);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b1;
      cyc(1);
      reg_rd_en = 1'b0;
      check(reg_rdata_q, 8'h5a, "back to back readback");
      cyc(1);
      $display("test reset_and_map done");
   endtask : test_reset_and_map

   task automatic test_demod();
      logic [7:0] v [5] = '{8'h80, 8'hc0, 8'h13, 8'h40, 8'h00};
      logic [7:0] d;
      foreach (v[i]) begin
         reg_wr(1'b0, 6'h0c, v[i]);
         cyc(1);
         reg_rd(1'b0, 6'h0c, d);
         check(d, v[i], "demod readback");
         check(demod_iq_q, v[i][7] & v[i][6], "iq mode");
         check(demod_cfg_error_q, v[i][7] & ~v[i][6], "iq without mixer");
         check(amd_mixer_q, v[i][6], "mixer select");
         check(squelch_ratio_high_q, v[i][4], "squelch ratio");
         check(agc_reset_alg_q, v[i][1], "agc algorithm");
         check(gain_control_ratio_q, v[i][0], "agc ratio");
      end
      reg_wr(1'b0, 6'h0c, 8'h2c);
      $display("test demod done");
   endtask : test_demod

   task automatic test_first_gain();
      logic [7:0] v;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         v = {3'(i), 3'(7 - i), 2'(i)};
         reg_wr(1'b0, 6'h0d, v);
         cyc(1);
         reg_rd(1'b0, 6'h0d, d);
         check(d, v, "gain1 readback");
         check({1'b0, am_first_stage_gain_q}, {1'b0, gain1_exp(i)}, "am gain1");
         check({1'b0, pm_first_stage_gain_q}, {1'b0, gain1_exp(7 - i)}, "pm gain1");
         check(low_freq_input_enable_q, v[1], "lf input");
         check(low_freq_split_mode_q, v[0], "lf split");
      end
      $display("test first_gain done");
   endtask : test_first_gain

   task automatic later_chk(input int c, input logic [3:0] code, win, stg, input string m);
      check({4'h0, c ? pm_later_stage_gain_q : am_later_stage_gain_q}, {4'h0, code}, m);
      check({4'h0, c ? pm_window_steps_q : am_window_steps_q}, {4'h0, win}, m);
      check({4'h0, c ? pm_stage_steps_q : am_stage_steps_q}, {4'h0, stg}, m);
   endtask : later_chk

   task automatic test_later_gain();
      int ce [2];
      int prev [2] = '{0, 0};
      logic [7:0] d;
      for (int i = 0; i < 16; i++) begin
         reg_wr(1'b0, 6'h0e, {4'(i), 4'(15 - i)});
         reg_rd(1'b0, 6'h0e, d);
         check(d, {4'(i), 4'(15 - i)}, "gain2 readback");
         cyc(2);
         for (int c = 0; c < 2; c++) begin
            later_chk(c, 4'(prev[c]), 4'(prev[c] > 4 ? 4 : prev[c]),
                      4'(prev[c] > 4 ? prev[c] - 4 : 0), "held before reload");
         end
         gain_reset_cmd = 1'b1;
         cyc(1);
         gain_reset_cmd = 1'b0;
         cyc(1);
         ce[0] = (i > 10) ? 10 : i;
         ce[1] = (15 - i > 10) ? 10 : 15 - i;
         for (int c = 0; c < 2; c++) begin
            later_chk(c, 4'(ce[c]), 4'(ce[c] > 4 ? 4 : ce[c]),
                      4'(ce[c] > 4 ? ce[c] - 4 : 0), "after reload");
            prev[c] = ce[c];
         end
      end
      $display("test later_gain done");
   endtask : test_later_gain

   task automatic test_passive();
      logic [7:0] v;
      logic [7:0] d;
      for (int i = 0; i < 32; i++) begin
         v = 8'(i * 8 + i % 8);
         reg_wr(1'b1, 6'h0b, v);
         cyc(1);
         reg_rd(1'b1, 6'h0b, d);
         check(d, v, "passive readback");
         check(onoff_fast_decay_q, v[7], "ook fast decay");
         check({6'h0, onoff_time_constant_q}, {6'h0, v[6:5]}, "onoff time constant");
         check({1'b0, onoff_threshold_pct_q}, (v[6:5] == 2'b00) ? 8'(55 - 10 * v[4:3])
               : 8'(80 - 5 * v[4:3]), "ook threshold");
         check({6'h0, amplitude_time_constant_q}, {6'h0, v[2:1]}, "amp time constant");
         check({1'b0, amplitude_threshold_pct_q}, v[0] ? 8'h5f : 8'h61, "ask thr");
      end
      $display("test passive done");
   endtask : test_passive

   task automatic test_squelch();
      tx_end = 1'b1;
      cyc(1);
      tx_end = 1'b0;
      cyc(755);
      check(squelch_active_q, 1'b0, "squelch early");
      cyc(1);
      check(squelch_active_q, 1'b1, "squelch on time");
      mask_timer_at_squelch = 1'b1;
      cyc(1);
      mask_timer_at_squelch = 1'b0;
      cyc(1);
      check(squelch_active_q, 1'b0, "squelch stop");
      reg_wr(1'b0, 6'h0c, 8'h0c);
      tx_end = 1'b1;
      cyc(1);
      tx_end = 1'b0;
      cyc(800);
      check(squelch_active_q, 1'b0, "squelch disabled");
      reg_wr(1'b0, 6'h0c, 8'h2c);
      $display("test squelch done");
   endtask : test_squelch

   task automatic test_agc();
      reg_wr(1'b0, 6'h0c, 8'h08);
      rx_on = 1'b1;
      cyc(3);
      check(agc_active_q, 1'b1, "agc start");
      scp_pulse(7);
      cyc(2);
      check(agc_active_q, 1'b1, "agc after seven");
      scp_pulse(1);
      cyc(2);
      check(agc_active_q, 1'b0, "agc after eight");
      rx_on = 1'b0;
      cyc(3);
      reg_wr(1'b0, 6'h0c, 8'h0c);
      rx_on = 1'b1;
      scp_pulse(10);
      cyc(2);
      check(agc_active_q, 1'b1, "agc whole period");
      reg_wr(1'b0, 6'h0c, 8'h04);
      cyc(2);
      check(agc_active_q, 1'b0, "agc disabled");
      rx_on = 1'b0;
      reg_wr(1'b0, 6'h0c, 8'h2c);
      $display("test agc done");
   endtask : test_agc

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   // generous bound: the tests need about 2000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      summarize();
   end

   initial begin
      cyc(4);
      sys_rst = 1'b0;
      test_reset_and_map();
      test_demod();
      test_first_gain();
      test_later_gain();
      test_passive();
      test_squelch();
      test_agc();
      summarize();
   end
endmodule : testbench
